// >>> rtl/plsm_pkg.sv
// constants and carrier types for the port / lcd segment pin multiplexer
package plsm_pkg;
  localparam int PLSM_WIDE_W = 8;
  localparam int PLSM_NARROW_W = 4;
  localparam int PLSM_SEG_N = 40;
  localparam int PLSM_STATIC_SEG_N = 12;
  localparam int PLSM_COM_N = 4;
  localparam int PLSM_SEG_A_LO = 12;
  localparam int PLSM_SEG_B_LO = 20;
  localparam int PLSM_SEG_C_LO = 28;
  localparam int PLSM_SEG_D_LO = 36;
  // reset: all pins in port mode, all inputs (safe, nothing driven)
  localparam logic [PLSM_WIDE_W-1:0] PLSM_FNSEL_RST = 8'h00;
  localparam logic [PLSM_WIDE_W-1:0] PLSM_DIR_RST = 8'h00;
  localparam logic [PLSM_WIDE_W-1:0] PLSM_OUT_RST = 8'h00;

  // per-port register write: one strobe per register, full-width data
  typedef struct packed {
    logic fnsel_we;
    logic dir_we;
    logic out_we;
    logic [PLSM_WIDE_W-1:0] wdata;
  } plsm_wr_t;

  // pad side of one port: drive level and drive enable per pin
  typedef struct packed {
    logic [PLSM_WIDE_W-1:0] o;
    logic [PLSM_WIDE_W-1:0] oe;
  } plsm_pad_t;

  typedef enum logic [0:0] {
    PLSM_DRIVE_DYNAMIC = 1'b0,
    PLSM_DRIVE_STATIC = 1'b1
  } plsm_drive_t;
endpackage

// >>> rtl/plsm_pin_mux.sv
// pin multiplexer for four ports shared with lcd segment lines
`timescale 1ns/1ps
module plsm_pin_mux
  import plsm_pkg::*;
#(
  parameter int WIDE_W = PLSM_WIDE_W,
  parameter int NARROW_W = PLSM_NARROW_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire plsm_wr_t wr_a,
  input wire plsm_wr_t wr_b,
  input wire plsm_wr_t wr_c,
  input wire plsm_wr_t wr_d,
  input wire logic [WIDE_W-1:0] port_a_pins_i,
  input wire logic [WIDE_W-1:0] port_b_pins_i,
  input wire logic [WIDE_W-1:0] port_c_pins_i,
  input wire logic [NARROW_W-1:0] port_d_pins_i,
  output plsm_pad_t port_a_pins,
  output plsm_pad_t port_b_pins,
  output plsm_pad_t port_c_pins,
  output logic [NARROW_W-1:0] port_d_pins_o,
  output logic [NARROW_W-1:0] port_d_pins_oe,
  output logic [WIDE_W-1:0] fnsel_port_a,
  output logic [WIDE_W-1:0] fnsel_port_b,
  output logic [WIDE_W-1:0] fnsel_port_c,
  output logic [NARROW_W-1:0] fnsel_port_d,
  output logic [WIDE_W-1:0] dir_port_a,
  output logic [WIDE_W-1:0] dir_port_b,
  output logic [WIDE_W-1:0] dir_port_c,
  output logic [NARROW_W-1:0] dir_port_d,
  output logic [WIDE_W-1:0] port_a_rd,
  output logic [WIDE_W-1:0] port_b_rd,
  output logic [WIDE_W-1:0] port_c_rd,
  output logic [NARROW_W-1:0] port_d_rd,
  input wire logic [PLSM_SEG_N-1:0] lcd_seg_drive,
  input wire plsm_drive_t lcd_drive_mode,
  input wire logic [PLSM_COM_N-1:0] lcd_com_drive,
  input wire logic lcd_static_com_drive,
  output logic [PLSM_STATIC_SEG_N-1:0] lcd_segment_lines,
  output logic [PLSM_COM_N-1:0] lcd_dynamic_backplanes,
  output logic lcd_static_backplane
);

  ////////////////////////////////////////////////////////////////////////////
  // pin registers and input synchronisers

  logic [WIDE_W-1:0] out_a_ff, out_b_ff, out_c_ff;
  logic [NARROW_W-1:0] out_d_ff;
  logic [WIDE_W-1:0] sa1_ff, sa2_ff, sb1_ff, sb2_ff, sc1_ff, sc2_ff;
  logic [NARROW_W-1:0] sd1_ff, sd2_ff;
  logic [PLSM_SEG_N-1:0] seg_ff;
  logic [PLSM_STATIC_SEG_N-1:0] lo_seg_ff;
  logic [PLSM_COM_N-1:0] com_ff;
  logic scom_ff;
  logic rst;
  assign rst = ~rst_n;

  // full-width write replaces every pin of the strobed register; unstrobed registers hold
  always_ff @(posedge clk) begin
    if (rst) begin
      fnsel_port_a <= PLSM_FNSEL_RST;
      fnsel_port_b <= PLSM_FNSEL_RST;
      fnsel_port_c <= PLSM_FNSEL_RST;
      fnsel_port_d <= PLSM_FNSEL_RST[NARROW_W-1:0];
    end else begin
      if (wr_a.fnsel_we) begin
        fnsel_port_a <= wr_a.wdata;
      end
      if (wr_b.fnsel_we) begin
        fnsel_port_b <= wr_b.wdata;
      end
      if (wr_c.fnsel_we) begin
        fnsel_port_c <= wr_c.wdata;
      end
      if (wr_d.fnsel_we) begin
        fnsel_port_d <= wr_d.wdata[NARROW_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_port_a <= PLSM_DIR_RST;
      dir_port_b <= PLSM_DIR_RST;
      dir_port_c <= PLSM_DIR_RST;
      dir_port_d <= PLSM_DIR_RST[NARROW_W-1:0];
    end else begin
      if (wr_a.dir_we) begin
        dir_port_a <= wr_a.wdata;
      end
      if (wr_b.dir_we) begin
        dir_port_b <= wr_b.wdata;
      end
      if (wr_c.dir_we) begin
        dir_port_c <= wr_c.wdata;
      end
      if (wr_d.dir_we) begin
        dir_port_d <= wr_d.wdata[NARROW_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_a_ff <= PLSM_OUT_RST;
      out_b_ff <= PLSM_OUT_RST;
      out_c_ff <= PLSM_OUT_RST;
      out_d_ff <= PLSM_OUT_RST[NARROW_W-1:0];
    end else begin
      if (wr_a.out_we) begin
        out_a_ff <= wr_a.wdata;
      end
      if (wr_b.out_we) begin
        out_b_ff <= wr_b.wdata;
      end
      if (wr_c.out_we) begin
        out_c_ff <= wr_c.wdata;
      end
      if (wr_d.out_we) begin
        out_d_ff <= wr_d.wdata[NARROW_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {sa1_ff, sa2_ff, sb1_ff, sb2_ff} <= '0;
      {sc1_ff, sc2_ff, sd1_ff, sd2_ff} <= '0;
    end else begin
      sa1_ff <= port_a_pins_i;
      sa2_ff <= sa1_ff;
      sb1_ff <= port_b_pins_i;
      sb2_ff <= sb1_ff;
      sc1_ff <= port_c_pins_i;
      sc2_ff <= sc1_ff;
      sd1_ff <= port_d_pins_i;
      sd2_ff <= sd1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lcd drive retiming

  // drive mode gates only the backplanes: segments reach lines 0..11 and the shared pins in both modes
  always_ff @(posedge clk) begin
    if (rst) begin
      seg_ff <= '0;
      lo_seg_ff <= '0;
      com_ff <= '0;
      scom_ff <= 1'b0;
    end else begin
      seg_ff <= lcd_seg_drive;
      lo_seg_ff <= lcd_seg_drive[PLSM_STATIC_SEG_N-1:0];
      com_ff <= (lcd_drive_mode == PLSM_DRIVE_DYNAMIC) ? lcd_com_drive : '0;
      scom_ff <= (lcd_drive_mode == PLSM_DRIVE_STATIC) ? lcd_static_com_drive : 1'b0;
    end
  end

  assign lcd_segment_lines = lo_seg_ff;
  assign lcd_dynamic_backplanes = com_ff;
  assign lcd_static_backplane = scom_ff;

  ////////////////////////////////////////////////////////////////////////////
  // pad multiplexing

  // segment owns the pin whatever the direction bit says
  function automatic logic [WIDE_W-1:0] pad_o(input logic [WIDE_W-1:0] fn,
                                              input logic [WIDE_W-1:0] seg,
                                              input logic [WIDE_W-1:0] dat);
    pad_o = (fn & seg) | (~fn & dat);
  endfunction

  function automatic logic [WIDE_W-1:0] pad_oe(input logic [WIDE_W-1:0] fn,
                                               input logic [WIDE_W-1:0] dir);
    pad_oe = fn | dir;
  endfunction

  logic [WIDE_W-1:0] seg_d_wide, fn_d_wide, dir_d_wide, out_d_wide, o_d_wide, oe_d_wide;
  assign seg_d_wide = {{(WIDE_W-NARROW_W){1'b0}}, seg_ff[PLSM_SEG_D_LO +: NARROW_W]};
  assign fn_d_wide = {{(WIDE_W-NARROW_W){1'b0}}, fnsel_port_d};
  assign dir_d_wide = {{(WIDE_W-NARROW_W){1'b0}}, dir_port_d};
  assign out_d_wide = {{(WIDE_W-NARROW_W){1'b0}}, out_d_ff};

  assign port_a_pins.o = pad_o(fnsel_port_a, seg_ff[PLSM_SEG_A_LO +: WIDE_W], out_a_ff);
  assign port_a_pins.oe = pad_oe(fnsel_port_a, dir_port_a);
  assign port_b_pins.o = pad_o(fnsel_port_b, seg_ff[PLSM_SEG_B_LO +: WIDE_W], out_b_ff);
  assign port_b_pins.oe = pad_oe(fnsel_port_b, dir_port_b);
  assign port_c_pins.o = pad_o(fnsel_port_c, seg_ff[PLSM_SEG_C_LO +: WIDE_W], out_c_ff);
  assign port_c_pins.oe = pad_oe(fnsel_port_c, dir_port_c);
  assign o_d_wide = pad_o(fn_d_wide, seg_d_wide, out_d_wide);
  assign oe_d_wide = pad_oe(fn_d_wide, dir_d_wide);
  assign port_d_pins_o = o_d_wide[NARROW_W-1:0];
  assign port_d_pins_oe = oe_d_wide[NARROW_W-1:0];

  // read: output pins show the latch, input pins the synchronised pad
  assign port_a_rd = (dir_port_a & out_a_ff) | (~dir_port_a & sa2_ff);
  assign port_b_rd = (dir_port_b & out_b_ff) | (~dir_port_b & sb2_ff);
  assign port_c_rd = (dir_port_c & out_c_ff) | (~dir_port_c & sc2_ff);
  assign port_d_rd = (dir_port_d & out_d_ff) | (~dir_port_d & sd2_ff);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence fn_write_a_s;
    wr_a.fnsel_we ##1 1'b1;
  endsequence

  reset_clear_a: assert property (@(posedge clk)
    rst |=> (fnsel_port_a == '0) && (dir_port_a == '0) && (port_a_pins.oe == '0))
    else $error("reset did not clear port a");
  // expected level is the controller's input one cycle back, not the retiming flop itself
  seg_own_a: assert property (@(posedge clk) disable iff (rst)
    ((port_a_pins.oe & fnsel_port_a) == fnsel_port_a) &&
    (((port_a_pins.o ^ $past(lcd_seg_drive[PLSM_SEG_A_LO +: WIDE_W]))
    & fnsel_port_a) == '0)) else $error("segment pin not driven");
  fnsel_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_a.fnsel_we |=> fnsel_port_a == $past(wr_a.wdata)) else $error("fnsel a not written");
  fnsel_hold_a: assert property (@(posedge clk) disable iff (rst)
    !wr_a.fnsel_we |=> $stable(fnsel_port_a)) else $error("fnsel a changed unasked");
  fnsel_iso_a: assert property (@(posedge clk) disable iff (rst)
    fn_write_a_s |-> $stable(dir_port_a) || $past(wr_a.dir_we))
    else $error("dir a disturbed");
  dir_port_b_a: assert property (@(posedge clk) disable iff (rst)
    (fnsel_port_b == '0) |-> port_b_pins.oe == dir_port_b) else $error("port b direction");
  seg_route_c_a: assert property (@(posedge clk) disable iff (rst)
    ((port_c_pins.o ^ $past(lcd_seg_drive[PLSM_SEG_C_LO +: WIDE_W])) & fnsel_port_c) == '0)
    else $error("port c segment routing");
  dir_port_d_a: assert property (@(posedge clk) disable iff (rst)
    ((port_d_pins_oe ^ dir_port_d) & ~fnsel_port_d) == '0) else $error("port d direction");
  static_com_a: assert property (@(posedge clk) disable iff (rst)
    (lcd_drive_mode == PLSM_DRIVE_DYNAMIC) [*2] |-> !lcd_static_backplane)
    else $error("static common in dynamic mode");
  // the first edge after reset still shows the cleared flops, so it is skipped
  dyn_com_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $past(lcd_drive_mode) == PLSM_DRIVE_DYNAMIC
    |-> lcd_dynamic_backplanes == $past(lcd_com_drive))
    else $error("dynamic common not passed");
  low_seg_pass_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> lcd_segment_lines == $past(lcd_seg_drive[PLSM_STATIC_SEG_N-1:0]))
    else $error("low segment lines not passed");

endmodule

// >>> sim/plsm_board.sv
// board-side model of the shared pads
`timescale 1ns/1ps
module plsm_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] o,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  // the board only wins where the device has released the pad
  assign pin = (oe & o) | (~oe & ext);
endmodule

// >>> sim/tb.sv
// self-checking bench for the port / lcd segment pin multiplexer
`timescale 1ns/1ps
module tb;
  import plsm_pkg::*;
  typedef struct {int due; int p; int k; logic [31:0] v;} plsm_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  plsm_wr_t wr[4] = '{default: '0};
  logic [39:0] seg = 40'hFFFFFFFFFF;
  plsm_drive_t mode = PLSM_DRIVE_DYNAMIC;
  logic [3:0] com = 4'hF;
  logic scom = 1'b1;
  logic [7:0] ex[4] = '{default: 8'h00};
  logic [7:0] fn[4], dr[4], ot[4], po[4], pe[4], rd[4], fo[4], dro[4];
  logic [7:0] msk[4] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};
  plsm_pad_t pa, pb, pc;
  logic [7:0] ia, ib, ic, ra, rb, rc, fa, fb, fc, da, db, dc;
  logic [3:0] id, pdo, pdoe, rdd, fd, dd, dyn;
  logic [11:0] segl;
  logic st;
  plsm_note_t q[$];
  plsm_note_t n;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  integer seed = 32'hF18093D1;
  ////////////////////////////////////////////////////////////////
  plsm_pin_mux DUT (.clk(clk), .rst_n(rst_n), .wr_a(wr[0]), .wr_b(wr[1]), .wr_c(wr[2]),
    .wr_d(wr[3]), .port_a_pins_i(ia), .port_b_pins_i(ib), .port_c_pins_i(ic),
    .port_d_pins_i(id), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
    .port_d_pins_o(pdo), .port_d_pins_oe(pdoe), .fnsel_port_a(fa), .fnsel_port_b(fb),
    .fnsel_port_c(fc), .fnsel_port_d(fd), .dir_port_a(da), .dir_port_b(db),
    .dir_port_c(dc), .dir_port_d(dd), .port_a_rd(ra), .port_b_rd(rb), .port_c_rd(rc),
    .port_d_rd(rdd), .lcd_seg_drive(seg), .lcd_drive_mode(mode), .lcd_com_drive(com),
    .lcd_static_com_drive(scom), .lcd_segment_lines(segl), .lcd_dynamic_backplanes(dyn),
    .lcd_static_backplane(st));
  plsm_board ba (.o(pa.o), .oe(pa.oe), .ext(ex[0]), .pin(ia));
  plsm_board bb (.o(pb.o), .oe(pb.oe), .ext(ex[1]), .pin(ib));
  plsm_board bc (.o(pc.o), .oe(pc.oe), .ext(ex[2]), .pin(ic));
  plsm_board #(.W(4)) bd (.o(pdo), .oe(pdoe), .ext(ex[3][3:0]), .pin(id));
  assign po = '{pa.o, pb.o, pc.o, {4'h0, pdo}};
  assign pe = '{pa.oe, pb.oe, pc.oe, {4'h0, pdoe}};
  assign rd = '{ra, rb, rc, {4'h0, rdd}};
  assign fo = '{fa, fb, fc, {4'h0, fd}};
  assign dro = '{da, db, dc, {4'h0, dd}};
  ////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // pad value is masked by its enable: an undriven pad has no defined level
  function automatic logic [31:0] obs(int p, int k);
    case (k)
      0: return {16'h0, po[p] & pe[p], pe[p]};
      1: return {24'h0, rd[p]};
      2: return {16'h0, fo[p], dro[p]};
      default: return {15'h0, segl, dyn, st};
    endcase
  endfunction

  task automatic note(int d, int p, int k, logic [31:0] v);
    q.push_back('{cyc + d, p, k, v});
  endtask

  // watcher: takes due notes oldest first, also cuts a hang short
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      check(obs(n.p, n.k), n.v);
    end
    if (cyc > 4000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    for (int p = 0; p < 4; p++) begin
      note(1, p, 0, 32'h0);
      note(1, p, 2, 32'h0);
    end
    note(1, 0, 3, 32'h0);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // writes direction, output data, then function select on all ports at once
  task automatic step();
    logic [7:0] sl;
    for (int w = 0; w < 3; w++) begin
      @(negedge clk);
      for (int p = 0; p < 4; p++)
        wr[p] = {w == 2, w == 0, w == 1, w == 0 ? dr[p] : w == 1 ? ot[p] : fn[p]};
    end
    for (int p = 0; p < 4; p++) begin
      sl = 8'({24'h0, seg} >> (12 + 8 * p)) & msk[p];
      note(1, p, 0, {16'h0, (fn[p] & sl) | (~fn[p] & dr[p] & ot[p]) & msk[p],
        (fn[p] | dr[p]) & msk[p]});
      note(1, p, 2, {16'h0, fn[p] & msk[p], dr[p] & msk[p]});
    end
    note(1, 0, 3, {15'h0, seg[11:0], mode == PLSM_DRIVE_STATIC ? 4'h0 : com,
      mode == PLSM_DRIVE_STATIC && scom});
    for (int p = 0; p < 4; p++) begin
      sl = 8'({24'h0, seg} >> (12 + 8 * p));
      note(3, p, 1, {24'h0, (dr[p] & ot[p] | ~dr[p] & (fn[p] & sl | ~fn[p] & ex[p]))
        & msk[p]});
    end
    @(negedge clk);
    for (int p = 0; p < 4; p++) wr[p] = '0;
    repeat (3) @(negedge clk);
  endtask

  initial begin
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      for (int p = 0; p < 4; p++) begin
        fn[p] = 8'($random(seed));
        dr[p] = 8'($random(seed));
        ot[p] = 8'($random(seed));
        ex[p] = 8'($random(seed));
      end
      seg = 40'({$random(seed), $random(seed)});
      com = 4'($random(seed));
      scom = 1'($random(seed));
      mode = plsm_drive_t'(i[0]);
      step();
    end
    $display("test random routing done");
    // one select bit flipped at a time; every other pin must hold
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 4; p++) fn[p] = fn[p] ^ (8'h01 << k);
      step();
    end
    $display("test single bit switching done");
    do_reset();
    repeat (4) @(negedge clk);
    $display("test reset in mid run done");
    finish_test();
  end
endmodule
